//--- effective_address_generator.sv
// Purpose: Effective address generation with X/Y circular buffers
// Assumes: Working register file read combinationally outside
// Notes: One request per cycle, answer registered one cycle later
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator
  import eagen_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Decoder request and register values
  input wire ea_req_t req_in,
  input wire logic [15:0] pointer_val_in,
  input wire logic [15:0] offset_val_in,
  // Literal decode helpers
  input wire logic [15:0] branch_lit_in,
  input wire logic [13:0] disable_lit_in,
  output logic signed [16:0] branch_disp_out,
  output logic [15:0] disable_count_out,
  // Address answer
  output ea_rsp_t rsp_out
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] x_ring_start_addr_q;
  logic [15:0] x_ring_end_addr_q;
  logic [15:0] y_ring_start_addr_q;
  logic [15:0] y_ring_end_addr_q;
  logic [15:0] circular_addressing_control_q;
  logic [1:0] wrap_seen_q;
  logic [1:0] wrap_seen_d;

  // Address decode
  wire logic acc_w = psel_in & penable_in & pwrite_in;
  wire logic hit_xs = paddr_in == OFF_X_START;
  wire logic hit_xe = paddr_in == OFF_X_END;
  wire logic hit_ys = paddr_in == OFF_Y_START;
  wire logic hit_ye = paddr_in == OFF_Y_END;
  wire logic hit_ct = paddr_in == OFF_CONTROL;
  wire logic hit_st = paddr_in == OFF_STATUS;
  wire logic hit_any = hit_xs | hit_xe | hit_ys | hit_ye | hit_ct | hit_st;

  // Zero-wait answer; unmapped addresses flag an error
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;
  assign prdata_out = hit_xs ? {16'h0000, x_ring_start_addr_q} :
                      hit_xe ? {16'h0000, x_ring_end_addr_q} :
                      hit_ys ? {16'h0000, y_ring_start_addr_q} :
                      hit_ye ? {16'h0000, y_ring_end_addr_q} :
                      hit_ct ? {16'h0000, circular_addressing_control_q} :
                      hit_st ? {30'h00000000, wrap_seen_q} : 32'h00000000;

  // Register writes
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      x_ring_start_addr_q <= RST_REG;
      x_ring_end_addr_q <= RST_REG;
      y_ring_start_addr_q <= RST_REG;
      y_ring_end_addr_q <= RST_REG;
      circular_addressing_control_q <= RST_CONTROL;
    end else if (acc_w) begin
      if (hit_xs) x_ring_start_addr_q <= pwdata_in[15:0];
      if (hit_xe) x_ring_end_addr_q <= pwdata_in[15:0];
      if (hit_ys) y_ring_start_addr_q <= pwdata_in[15:0];
      if (hit_ye) y_ring_end_addr_q <= pwdata_in[15:0];
      if (hit_ct) circular_addressing_control_q <= pwdata_in[15:0];
    end
  end

  // ----------------------------------------
  // Ring selection
  // ----------------------------------------
  wire logic [3:0] x_pointer_select = circular_addressing_control_q[XSEL_LSB +: 4];
  wire logic [3:0] y_pointer_select = circular_addressing_control_q[YSEL_LSB +: 4];
  wire logic x_circular_enable = circular_addressing_control_q[XEN_BIT];
  wire logic y_circular_enable = circular_addressing_control_q[YEN_BIT];
  wire logic x_ring_on = x_circular_enable & (x_pointer_select != SEL_NONE);
  wire logic y_ring_on = y_circular_enable & (y_pointer_select != SEL_NONE);

  // ----------------------------------------
  // Prefetch routing and legality
  // ----------------------------------------
  wire logic is_pf = req_in.mode == MODE_PREFETCH;
  wire logic pf_x = (req_in.pointer_reg == REG_W8) | (req_in.pointer_reg == REG_W9);
  wire logic pf_y = (req_in.pointer_reg == REG_W10) | (req_in.pointer_reg == REG_W11);
  wire logic space_y = is_pf & pf_y;
  wire logic pf_idx_ok = (req_in.pointer_reg == REG_W9) | (req_in.pointer_reg == REG_W11);
  wire logic pf_indexed = is_pf & (req_in.step == 16'sd0) & (req_in.literal[0]);
  wire logic [15:0] step_mag = req_in.step[15] ? 16'(-req_in.step) : 16'(req_in.step);
  wire logic pf_step_ok = (req_in.step == 16'sd0) | (step_mag == 16'd2) |
                          (step_mag == 16'd4) | (step_mag == 16'd6);
  wire logic pf_illegal = is_pf & (~(pf_x | pf_y) | ~pf_step_ok |
                          (pf_indexed & ~pf_idx_ok));

  // ----------------------------------------
  // Raw address formation
  // ----------------------------------------
  wire logic [15:0] step_u = 16'(req_in.step);
  wire logic [15:0] sum_step = pointer_val_in + step_u;
  wire logic [15:0] sum_idx = pointer_val_in + offset_val_in;
  wire logic [15:0] sum_lit = pointer_val_in + req_in.literal;
  logic [15:0] raw_addr;
  logic modifies;
  logic checks;

  // Mode selection of the raw effective address
  always_comb begin
    raw_addr = pointer_val_in;
    modifies = 1'b0;
    checks = 1'b1;
    unique case (req_in.mode)
      MODE_FILE: begin
        raw_addr = {3'b000, req_in.file_addr} & NEAR_MASK;
        checks = 1'b0;
      end
      MODE_DIRECT: begin
        raw_addr = pointer_val_in;
        checks = 1'b0;
      end
      MODE_INDIRECT: raw_addr = pointer_val_in;
      MODE_POST: begin
        raw_addr = pointer_val_in;
        modifies = 1'b1;
      end
      MODE_PRE: begin
        raw_addr = sum_step;
        modifies = 1'b1;
      end
      MODE_INDEXED: raw_addr = sum_idx;
      MODE_LITOFS: raw_addr = sum_lit;
      MODE_PREFETCH: begin
        raw_addr = pf_indexed ? sum_idx : pointer_val_in;
        modifies = ~pf_indexed & (req_in.step != 16'sd0);
      end
    endcase
  end

  // ----------------------------------------
  // Circular correction
  // ----------------------------------------
  // X ring outside Y space, Y ring in Y space and in non-prefetch modes; X wins when both match
  wire logic ring_x_hit = x_ring_on & ~space_y & (req_in.pointer_reg == x_pointer_select);
  wire logic ring_y_hit = y_ring_on & (space_y | ~is_pf) & (req_in.pointer_reg == y_pointer_select);
  wire logic use_y = ring_y_hit & ~ring_x_hit;
  wire logic ring_hit = (ring_x_hit | ring_y_hit) & checks;
  wire logic [15:0] r_start = use_y ? y_ring_start_addr_q : x_ring_start_addr_q;
  wire logic [15:0] r_end = use_y ? y_ring_end_addr_q : x_ring_end_addr_q;
  wire logic [15:0] r_span = r_end - r_start;
  wire logic [15:0] r_len_raw = r_span + 16'h0002;
  wire logic [15:0] r_len = (r_span > MAX_RING_BYTES) ? MAX_RING_BYTES : r_len_raw;
  wire logic pow2 = (r_len & (r_len - 16'h0001)) == 16'h0000;
  wire logic going_down = req_in.step[15];
  wire logic chk_up = pow2 | ~going_down;
  wire logic chk_dn = pow2 | going_down;
  // Post-modify and prefetch check the updated pointer, others the address itself
  wire logic [15:0] probe = (req_in.mode == MODE_POST || is_pf) ? sum_step : raw_addr;
  wire logic over_up = chk_up & (probe > r_end);
  wire logic over_dn = chk_dn & (probe < r_start);
  wire logic [15:0] fix_up = probe - r_len;
  wire logic [15:0] fix_dn = probe + r_len;
  wire logic [15:0] fixed_probe = ~ring_hit ? probe : over_up ? fix_up : over_dn ? fix_dn : probe;
  wire logic probe_is_ea = ~((req_in.mode == MODE_POST) | is_pf);
  wire logic [15:0] ea_pre = probe_is_ea ? fixed_probe : raw_addr;
  wire logic [15:0] ea_final = (use_y & ring_hit) ? (ea_pre & WORD_MASK) : ea_pre;
  wire logic [15:0] wb_val = (use_y & ring_hit) ? (fixed_probe & WORD_MASK) : fixed_probe;
  wire logic wrapped = ring_hit & (over_up | over_dn);

  // ----------------------------------------
  // Answer register
  // ----------------------------------------
  ea_rsp_t rsp_d;
  ea_rsp_t rsp_q;

  // Next answer
  always_comb begin
    rsp_d = '0;
    rsp_d.valid = req_in.valid;
    rsp_d.addr = ea_final;
    rsp_d.space_y = space_y;
    rsp_d.wb_en = req_in.valid & modifies & ~pf_illegal;
    rsp_d.wb_reg = req_in.pointer_reg;
    rsp_d.wb_data = wb_val;
    // Result to W0 for an implied file-mode destination, else to the pointer register
    rsp_d.dest_reg = (req_in.mode == MODE_FILE && req_in.dest_is_implied_working_reg) ? REG_W0 : req_in.pointer_reg;
    rsp_d.illegal = req_in.valid & pf_illegal;
  end

  // Sticky wrap flags, set wins over clear
  always_comb begin
    wrap_seen_d = wrap_seen_q;
    if (acc_w && hit_st) wrap_seen_d = wrap_seen_q & ~pwdata_in[1:0];
    if (req_in.valid && wrapped) wrap_seen_d[use_y] = 1'b1;
  end

  // Answer and status flops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_q <= '0;
      wrap_seen_q <= 2'b00;
      branch_disp_out <= '0;
      disable_count_out <= 16'h0000;
    end else begin
      rsp_q <= rsp_d;
      wrap_seen_q <= wrap_seen_d;
      branch_disp_out <= 17'(signed'(branch_lit_in));
      disable_count_out <= {2'b00, disable_lit_in};
    end
  end

  assign rsp_out = rsp_q;

endmodule : effective_address_generator
`default_nettype wire

//--- eagen_pkg.sv
// Purpose: Constants and types for the effective address generator
// Assumes: 16-bit data space, byte addresses, 16 working registers
// Notes: Register offsets are APB byte addresses
package eagen_pkg;
  localparam logic [7:0] OFF_X_START = 8'h00;
  localparam logic [7:0] OFF_X_END = 8'h04;
  localparam logic [7:0] OFF_Y_START = 8'h08;
  localparam logic [7:0] OFF_Y_END = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h00ff;
  localparam int XSEL_LSB = 0;
  localparam int YSEL_LSB = 4;
  localparam int YEN_BIT = 14;
  localparam int XEN_BIT = 15;
  localparam logic [3:0] SEL_NONE = 4'hf;
  localparam logic [3:0] REG_W0 = 4'h0;
  localparam logic [3:0] REG_W8 = 4'h8;
  localparam logic [3:0] REG_W9 = 4'h9;
  localparam logic [3:0] REG_W10 = 4'ha;
  localparam logic [3:0] REG_W11 = 4'hb;
  localparam logic [15:0] NEAR_MASK = 16'h1fff;
  localparam logic [15:0] MAX_RING_BYTES = 16'hfffe;
  localparam logic [15:0] WORD_MASK = 16'hfffe;

  // Addressing modes from the decoder
  typedef enum logic [2:0] {
    MODE_FILE, MODE_DIRECT, MODE_INDIRECT, MODE_POST,
    MODE_PRE, MODE_INDEXED, MODE_LITOFS, MODE_PREFETCH
  } addr_mode_t;

  // Decoder request
  typedef struct packed {
    logic valid;
    addr_mode_t mode;
    logic [3:0] pointer_reg;
    logic [3:0] base_offset_reg;
    logic [12:0] file_addr;
    logic [15:0] literal;
    logic signed [15:0] step;
    logic dest_is_implied_working_reg;
    logic is_write;
  } ea_req_t;

  // Answer toward data memory and register file
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic space_y;
    logic wb_en;
    logic [3:0] wb_reg;
    logic [15:0] wb_data;
    logic [3:0] dest_reg;
    logic illegal;
  } ea_rsp_t;
endpackage : eagen_pkg

//--- eagen_assertions.sv
// Purpose: Port checks for the effective address generator
// Assumes: Bound to the top module, one clock domain
// Notes: Answers are registered one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module eagen_assertions
  import eagen_pkg::*;
(
  // Clock, reset and APB
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  // Requests, literals and answers
  input wire ea_req_t req_in,
  input wire logic [15:0] pointer_val_in,
  input wire logic [15:0] branch_lit_in,
  input wire logic [13:0] disable_lit_in,
  input wire logic signed [16:0] branch_disp_out,
  input wire logic [15:0] disable_count_out,
  input wire ea_rsp_t rsp_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Request qualifiers
  wire logic req_v = req_in.valid;
  wire addr_mode_t req_m = req_in.mode;
  wire logic pf_ok = req_in.pointer_reg[3:2] == 2'b10;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // near field width
  property p_file; req_v && req_m == MODE_FILE |=> rsp_out.addr == {3'h0, $past(req_in.file_addr)}; endproperty
  a_file: assert property (p_file) else $error("file address wrong");
  property p_dest; req_v && req_m == MODE_FILE && req_in.dest_is_implied_working_reg |=> rsp_out.dest_reg == REG_W0; endproperty
  a_dest: assert property (p_dest) else $error("file destination wrong");
  property p_plain; req_v && req_m == MODE_INDIRECT |=> rsp_out.addr == $past(pointer_val_in) && !rsp_out.wb_en;
  endproperty
  a_plain: assert property (p_plain) else $error("indirect address wrong");
  property p_post; req_v && req_m == MODE_POST |=> rsp_out.wb_en && rsp_out.addr == $past(pointer_val_in)
    && rsp_out.wb_reg == $past(req_in.pointer_reg); endproperty
  a_post: assert property (p_post) else $error("post modify wrong");
  property p_pre; req_v && req_m == MODE_PRE |-> ##1 rsp_out.wb_en && rsp_out.wb_data == rsp_out.addr; endproperty
  a_pre: assert property (p_pre) else $error("pre modify wrong");
  property p_keep; req_v && (req_m == MODE_INDEXED || req_m == MODE_LITOFS) |=> rsp_out.valid && !rsp_out.wb_en;
  endproperty
  a_keep: assert property (p_keep) else $error("offset mode wrote pointer");
  property p_route; req_v && req_m == MODE_PREFETCH && pf_ok |=> rsp_out.space_y == $past(req_in.pointer_reg[1]);
  endproperty
  a_route: assert property (p_route) else $error("prefetch space wrong");
  property p_refuse; req_v && req_m == MODE_PREFETCH && !pf_ok |=> rsp_out.illegal && !rsp_out.wb_en; endproperty
  a_refuse: assert property (p_refuse) else $error("prefetch not refused");
  property p_lit; $past(resetn_in) |-> branch_disp_out == {$past(branch_lit_in[15]), $past(branch_lit_in)}
    && disable_count_out == {2'h0, $past(disable_lit_in)}; endproperty
  a_lit: assert property (p_lit) else $error("literal extension wrong");
  // Zero wait slave
  property p_ready; psel_in && penable_in |-> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  // Main scenarios
  c_post: cover property (req_v && req_m == MODE_POST);
  c_fetch: cover property (req_v && req_m == MODE_PREFETCH && pf_ok);
  c_bad: cover property (rsp_out.valid && rsp_out.illegal);
endmodule : eagen_assertions
bind effective_address_generator eagen_assertions eagen_assertions_i (.clk_in, .resetn_in, .psel_in, .penable_in,
  .pready_out, .req_in, .pointer_val_in, .branch_lit_in, .disable_lit_in, .branch_disp_out, .disable_count_out,
  .rsp_out);
`default_nettype wire

//--- eagen_regfile_model.sv
// Purpose: Working register file on the decoder side
// Assumes: Write-back arrives with the answer
// Notes: Register n resets to n times 0x100
`timescale 1ns/1ps
`default_nettype none
module eagen_regfile_model
  import eagen_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Request and answer
  input wire ea_req_t req_in,
  input wire ea_rsp_t rsp_in,
  // Operand values
  output logic [15:0] pointer_val_out,
  output logic [15:0] offset_val_out
);
  logic [15:0] regs_q [16];
  assign pointer_val_out = regs_q[req_in.pointer_reg];
  assign offset_val_out = regs_q[req_in.base_offset_reg];
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 16; i++) regs_q[i] <= 16'(i * 256);
    end else if (rsp_in.valid && rsp_in.wb_en) begin
      regs_q[rsp_in.wb_reg] <= rsp_in.wb_data;
    end
  end
endmodule : eagen_regfile_model
`default_nettype wire

//--- tb_effective_address_generator.sv
// Purpose: Register and addressing mode checks
// Assumes: Zero wait APB, answer one cycle after request
// Notes: Rings sit at 0x0700 to 0x0706, eight bytes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_effective_address_generator
  import eagen_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  ea_req_t req;
  ea_rsp_t rsp;
  logic [15:0] ptr_v, ofs_v, blit, dcnt, ex;
  logic [13:0] dlit;
  logic signed [16:0] bdisp;
  int err_total, compares;
  logic [7:0] roff [4] = '{OFF_X_START, OFF_X_END, OFF_Y_START, OFF_Y_END};
  logic [15:0] rval [4] = '{16'h0700, 16'h0706, 16'h0700, 16'h0706};
  always #50 clk = ~clk;
  effective_address_generator effective_address_generator_i (.clk_in(clk), .resetn_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .req_in(req), .pointer_val_in(ptr_v), .offset_val_in(ofs_v),
    .branch_lit_in(blit), .disable_lit_in(dlit), .branch_disp_out(bdisp), .disable_count_out(dcnt), .rsp_out(rsp));
  eagen_regfile_model eagen_regfile_model_i (.clk_in(clk), .resetn_in(rst_n), .req_in(req), .rsp_in(rsp),
    .pointer_val_out(ptr_v), .offset_val_out(ofs_v));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Verdict and end of run
  task automatic final_report;
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // One APB transfer, read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e, input logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin err_total++; final_report(); end
    if (!w) `CHK(prdata, {16'h0000, e})
    `CHK(pslverr, er)
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // One request, answer checked one cycle later
  task automatic ea(input addr_mode_t m, input logic [3:0] p, input logic [15:0] lit, input logic [15:0] st,
    input logic [15:0] e, input logic wb, input logic il);
    @(posedge clk);
    req <= '{1'b1, m, p, 4'h2, lit[12:0], lit, st, 1'b1, 1'b0};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    if (!il) `CHK(rsp.addr, e)
    `CHK(rsp.wb_en, wb)
    `CHK(rsp.illegal, il)
  endtask : ea
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; req = '0; blit = 0; dlit = 0;
    err_total = 0; compares = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, OFF_CONTROL, 0, RST_CONTROL, 0);
    apb(1, 8'h18, 16'h1234, 0, 1);
    apb(0, 8'h18, 0, 16'h0000, 1);
    for (int i = 0; i < 4; i++) apb(0, roff[i], 0, RST_REG, 0);
    for (int i = 0; i < 4; i++) apb(1, roff[i], rval[i], 0, 0);
    for (int i = 0; i < 4; i++) apb(0, roff[i], 0, rval[i], 0);
    blit <= 16'h8000; dlit <= 14'h3fff;
    @(posedge clk); #1;
    `CHK(bdisp, 17'h18000)
    `CHK(dcnt, 16'h3fff)
    ea(MODE_FILE, 4'h5, 16'hffff, 0, 16'h1fff, 0, 0);
    ea(MODE_INDIRECT, 4'h3, 0, 0, 16'h0300, 0, 0);
    ea(MODE_POST, 4'h3, 0, 16'h0002, 16'h0300, 1, 0);
    ea(MODE_INDIRECT, 4'h3, 0, 0, 16'h0302, 0, 0);
    ea(MODE_PRE, 4'h4, 0, 16'hfffe, 16'h03fe, 1, 0);
    ea(MODE_INDEXED, 4'h5, 0, 0, 16'h0700, 0, 0);
    ea(MODE_LITOFS, 4'h6, 16'h0010, 0, 16'h0610, 0, 0);
    // Prefetch steps 2, 4, 6 stay within X space on the X pointer
    ex = 16'h0800;
    for (int k = 1; k < 4; k++) begin
      ea(MODE_PREFETCH, REG_W8, 0, 16'(2 * k), ex, 1, 0);
      ex = ex + 16'(2 * k);
    end
    ea(MODE_PREFETCH, REG_W10, 0, 16'h0002, 16'h0a00, 1, 0);
    ea(MODE_PREFETCH, REG_W9, 16'h0001, 0, 16'h0b00, 0, 0);
    ea(MODE_PREFETCH, REG_W8, 16'h0001, 0, 0, 0, 1);
    ea(MODE_PREFETCH, 4'h3, 0, 16'h0002, 0, 0, 1);
    ea(MODE_PREFETCH, REG_W11, 0, 16'h0008, 0, 0, 1);
    // X ring on pointer 7, away from the stack registers
    apb(1, OFF_CONTROL, 16'h80f7, 0, 0);
    ea(MODE_PRE, 4'h7, 0, 16'h000a, 16'h0702, 1, 0);
    ea(MODE_LITOFS, 4'h7, 16'h0008, 0, 16'h0702, 0, 0);
    ea(MODE_PRE, 4'h7, 0, 16'hfff6, 16'h0700, 1, 0);
    apb(1, OFF_CONTROL, 16'h00f7, 0, 0);
    ea(MODE_LITOFS, 4'h7, 16'h0008, 0, 16'h0708, 0, 0);
    apb(1, OFF_CONTROL, 16'h80ff, 0, 0);
    ea(MODE_LITOFS, 4'h7, 16'h0008, 0, 16'h0708, 0, 0);
    apb(1, OFF_CONTROL, 16'h407f, 0, 0);
    ea(MODE_LITOFS, 4'h7, 16'h0009, 0, 16'h0700, 0, 0);
    apb(1, OFF_CONTROL, 16'h007f, 0, 0);
    ea(MODE_LITOFS, 4'h7, 16'h0009, 0, 16'h0709, 0, 0);
    // Both rings wrapped above, so both sticky flags stand until cleared
    apb(0, OFF_STATUS, 0, 16'h0003, 0);
    apb(1, OFF_STATUS, 16'h0003, 0, 0);
    apb(0, OFF_STATUS, 0, 16'h0000, 0);
    final_report();
  end
endmodule : tb_effective_address_generator
`default_nettype wire
